// file: shared/bms_pkg.sv
// Package with constants and types for the boot mode selector.
`default_nettype none
package bms_pkg;
  localparam int FUSE_W = 32;
  localparam int SRC_LSB = 0;
  localparam int SRC_W = 3;
  localparam int EMMC_LSB = 12;
  localparam int EMMC_W = 3;
  localparam logic [2:0] SRC_UNPROG = 3'h0;
  localparam logic [2:0] EMMC_ENABLE = 3'h1;
  localparam logic [31:0] ROM_BASE = 32'h1fff_e000;
  localparam int ROM_BYTES = 8192;
  localparam int START_DELAY = 0;

  typedef enum logic [2:0] {
    BMS_ROM = 3'b000,
    BMS_UART_SRAM = 3'b001,
    BMS_UART_FLASH = 3'b010,
    BMS_SPI_SRAM = 3'b011,
    BMS_DIRECT1 = 3'b100,
    BMS_DIRECT4_EXTERNAL_CRYSTAL_OSC = 3'b101,
    BMS_DIRECT4_IRC = 3'b110,
    BMS_EMMC_SRAM = 3'b111
  } bms_mode_t;

  typedef enum logic [1:0] {
    BMS_IF_NONE = 2'b00,
    BMS_IF_SERIAL = 2'b01,
    BMS_IF_SPI = 2'b10,
    BMS_IF_EMMC = 2'b11
  } bms_if_t;

  typedef struct packed {
    bms_mode_t mode;
    bms_if_t load_if;
    logic to_sram;
    logic to_flash;
    logic direct_exec;
    logic flash_quad;
    logic use_external_crystal_osc;
    logic use_irc;
  } bms_cfg_t;
endpackage
`default_nettype wire

// file: hw/bms_boot_mode_selector.sv
// Boot mode selector: picks the boot mode from fuses or strap pins.
// Overview of operation
// RULE1 - Zero fuse boot-source field means boot mode comes from three strap pins.
// RULE2 - Fuse word 0 bits 2..0 give the boot-mode code when programmed.
// RULE3 - Code 000 boots from the internal boot ROM.
// RULE4 - Code 001 downloads over second serial port into SRAM, runs from SRAM.
// RULE5 - Code 010 downloads over serial port into flash, quad SPI, fast RC.
// RULE6 - Code 011 downloads through third SPI controller into SRAM, fast RC.
// RULE7 - Code 011 means eMMC download only when fuse word 1 bits 14..12 are 001.
// RULE8 - Code 100 runs directly from internal flash, 1-bit SPI, fast RC.
// RULE9 - Code 101 runs directly from internal flash, 4-bit SPI, crystal clock.
// RULE10 - Code 110 runs directly from internal flash, 4-bit SPI, fast RC.
// RULE11 - After reset the processor fetches from the 8 KB boot ROM immediately.
// RULE12 - Strap pins must hold their levels when reset is released.
// RULE13 - Programmed fuse field ignores strap pins; mode latches once per reset.
`timescale 1ns/1ps
`default_nettype none
module bms_boot_mode_selector
  import bms_pkg::*;
#(
  parameter int SYNC_STAGES = 3
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [bms_pkg::FUSE_W-1:0] fuse_word0,
  input wire logic [bms_pkg::FUSE_W-1:0] fuse_word1,
  input wire logic [2:0] boot_select_pins,
  output logic mode_valid,
  output bms_pkg::bms_cfg_t boot_cfg,
  output logic rom_fetch_en,
  output logic [31:0] rom_fetch_base,
  output logic second_serial_port_en,
  output logic third_spi_controller_en,
  output logic serial_boot_port_pins_en,
  output logic fast_internal_rc_osc_sel,
  output logic external_crystal_osc_sel
);
  import bms_pkg::*;

  // Strap pins are asynchronous; a level counts once the last two agree.
  localparam int SYNC_W = SYNC_STAGES * 3;
  logic [SYNC_W-1:0] pin_shift;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pin_shift <= '0;
    end else begin
      pin_shift <= {pin_shift[SYNC_W-4:0], boot_select_pins};
    end
  end

  wire [2:0] pin_s2 = pin_shift[SYNC_W-4 -: 3];
  wire [2:0] pin_s3 = pin_shift[SYNC_W-1 -: 3];
  wire pins_stable = (pin_s2 == pin_s3);
  wire [2:0] fuse_src = fuse_word0[SRC_LSB +: SRC_W]; // [RULE2]
  wire fuse_unprog = (fuse_src == SRC_UNPROG); // [RULE1]
  wire emmc_on = (fuse_word1[EMMC_LSB +: EMMC_W] == EMMC_ENABLE); // [RULE7]
  // Fuse wins whenever programmed, so pins are not even looked at.
  wire [2:0] raw_code = fuse_unprog ? pin_s3 : fuse_src; // [RULE1] [RULE13]
  // A code of 111, from fuse or straps, has no defined mode; it falls back to ROM boot.
  wire [2:0] legal_code = (raw_code == 3'h7) ? 3'h0 : raw_code;
  wire bms_mode_t sel_mode = (legal_code == 3'h3 && emmc_on) ?
      BMS_EMMC_SRAM : bms_mode_t'(legal_code); // [RULE7]

  // The strap needs a sample window after release before it can be trusted.
  logic [1:0] settle;
  wire ready_to_latch = fuse_unprog ? (settle == 2'h3 && pins_stable) :
      1'b1;

  logic latched;
  bms_mode_t mode;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      settle <= 2'h0;
    end else if (settle != 2'h3) begin
      settle <= settle + 2'h1;
    end
  end

  // Mode is taken once and held until the next reset.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      latched <= 1'b0;
      mode <= BMS_ROM;
    end else if (!latched && ready_to_latch) begin
      latched <= 1'b1; // [RULE13] [RULE12]
      mode <= sel_mode;
    end
  end

  bms_cfg_t next_cfg;
  always_comb begin
    next_cfg = '0;
    next_cfg.mode = mode;
    case (mode)
      BMS_ROM: begin
        next_cfg.load_if = BMS_IF_NONE; // [RULE3]
      end
      BMS_UART_SRAM: begin
        next_cfg.load_if = BMS_IF_SERIAL; // [RULE4]
        next_cfg.to_sram = 1'b1;
      end
      BMS_UART_FLASH: begin
        next_cfg.load_if = BMS_IF_SERIAL; // [RULE5]
        next_cfg.to_flash = 1'b1;
        next_cfg.flash_quad = 1'b1;
        next_cfg.use_irc = 1'b1;
      end
      BMS_SPI_SRAM: begin
        next_cfg.load_if = BMS_IF_SPI; // [RULE6]
        next_cfg.to_sram = 1'b1;
        next_cfg.use_irc = 1'b1;
      end
      BMS_EMMC_SRAM: begin
        next_cfg.load_if = BMS_IF_EMMC; // [RULE7]
        next_cfg.to_sram = 1'b1;
        next_cfg.use_irc = 1'b1;
      end
      BMS_DIRECT1: begin
        next_cfg.direct_exec = 1'b1; // [RULE8]
        next_cfg.use_irc = 1'b1;
      end
      BMS_DIRECT4_EXTERNAL_CRYSTAL_OSC: begin
        next_cfg.direct_exec = 1'b1; // [RULE9]
        next_cfg.flash_quad = 1'b1;
        next_cfg.use_external_crystal_osc = 1'b1;
      end
      BMS_DIRECT4_IRC: begin
        next_cfg.direct_exec = 1'b1; // [RULE10]
        next_cfg.flash_quad = 1'b1;
        next_cfg.use_irc = 1'b1;
      end
      default: begin
        next_cfg.load_if = BMS_IF_NONE;
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      boot_cfg <= '0;
      mode_valid <= 1'b0;
    end else begin
      boot_cfg <= next_cfg;
      mode_valid <= latched;
    end
  end

  // The boot ROM runs first in every mode; it reads boot_cfg to branch.
  assign rom_fetch_en = ~rst; // [RULE11]
  assign rom_fetch_base = ROM_BASE; // [RULE11]
  assign second_serial_port_en = mode_valid &&
      (boot_cfg.load_if == BMS_IF_SERIAL);
  assign serial_boot_port_pins_en = second_serial_port_en; // [RULE4]
  assign third_spi_controller_en = mode_valid &&
      (boot_cfg.load_if == BMS_IF_SPI); // [RULE6]
  assign fast_internal_rc_osc_sel = mode_valid && boot_cfg.use_irc;
  assign external_crystal_osc_sel = mode_valid && boot_cfg.use_external_crystal_osc;

  property p_fuse_wins;
    @(posedge clock) disable iff (rst)
    (!latched && !fuse_unprog) |=> latched &&
      (($past(fuse_src) == 3'h7) ? (mode == BMS_ROM) :
      (mode[1:0] == $past(fuse_src[1:0])));
  endproperty
  a_fuse_wins: assert property (p_fuse_wins) // [RULE2]
    else $error("fuse code not latched");

  property p_pins_used;
    @(posedge clock) disable iff (rst)
    (!latched && ready_to_latch && fuse_unprog && pin_s3 == 3'h1) |=>
      mode == BMS_UART_SRAM;
  endproperty
  a_pins_used: assert property (p_pins_used) // [RULE1]
    else $error("strap code not latched");

  property p_hold;
    @(posedge clock) disable iff (rst)
    latched |=> latched && $stable(mode);
  endproperty
  a_hold: assert property (p_hold) // [RULE13]
    else $error("mode changed after latch");

  property p_emmc;
    @(posedge clock) disable iff (rst)
    (!latched && ready_to_latch && legal_code == 3'h3) |=>
      (mode == BMS_EMMC_SRAM) == $past(emmc_on);
  endproperty
  a_emmc: assert property (p_emmc) // [RULE7]
    else $error("eMMC choice wrong");

  property p_direct1;
    @(posedge clock) disable iff (rst)
    mode_valid && boot_cfg.mode == BMS_DIRECT1 |->
      boot_cfg.direct_exec && !boot_cfg.flash_quad && fast_internal_rc_osc_sel;
  endproperty
  a_direct1: assert property (p_direct1) // [RULE8]
    else $error("direct 1-bit config wrong");

  property p_direct_external_crystal_osc;
    @(posedge clock) disable iff (rst)
    mode_valid && boot_cfg.mode == BMS_DIRECT4_EXTERNAL_CRYSTAL_OSC |->
      boot_cfg.flash_quad && external_crystal_osc_sel &&
      !fast_internal_rc_osc_sel;
  endproperty
  a_direct_external_crystal_osc: assert property (p_direct_external_crystal_osc) // [RULE9]
    else $error("direct crystal config wrong");

  property p_uart_flash;
    @(posedge clock) disable iff (rst)
    mode_valid && boot_cfg.mode == BMS_UART_FLASH |->
      serial_boot_port_pins_en && boot_cfg.to_flash && boot_cfg.flash_quad;
  endproperty
  a_uart_flash: assert property (p_uart_flash) // [RULE5]
    else $error("serial flash config wrong");

  property p_valid_soon;
    @(posedge clock) disable iff (rst)
    $rose(rom_fetch_en) |-> ##[1:8] mode_valid;
  endproperty
  a_valid_soon: assert property (p_valid_soon) // [RULE11]
    else $error("mode not valid in time");

  // Each mode's outputs are checked against its own rule, not the decoder.
  property p_rom;
    @(posedge clock) disable iff (rst)
    mode_valid && boot_cfg.mode == BMS_ROM |->
      boot_cfg.load_if == BMS_IF_NONE && !boot_cfg.direct_exec &&
      !second_serial_port_en && !third_spi_controller_en;
  endproperty
  a_rom: assert property (p_rom) // [RULE3]
    else $error("ROM boot config wrong");

  property p_uart_sram;
    @(posedge clock) disable iff (rst)
    mode_valid && boot_cfg.mode == BMS_UART_SRAM |->
      serial_boot_port_pins_en && boot_cfg.to_sram && !boot_cfg.direct_exec;
  endproperty
  a_uart_sram: assert property (p_uart_sram) // [RULE4]
    else $error("serial SRAM config wrong");

  property p_spi_sram;
    @(posedge clock) disable iff (rst)
    mode_valid && boot_cfg.mode == BMS_SPI_SRAM |->
      third_spi_controller_en && boot_cfg.to_sram &&
      fast_internal_rc_osc_sel && !second_serial_port_en;
  endproperty
  a_spi_sram: assert property (p_spi_sram) // [RULE6]
    else $error("SPI SRAM config wrong");

  property p_emmc_cfg;
    @(posedge clock) disable iff (rst)
    mode_valid && boot_cfg.mode == BMS_EMMC_SRAM |->
      boot_cfg.load_if == BMS_IF_EMMC && boot_cfg.to_sram &&
      !third_spi_controller_en && fast_internal_rc_osc_sel;
  endproperty
  a_emmc_cfg: assert property (p_emmc_cfg) // [RULE7]
    else $error("eMMC config wrong");

  property p_direct_irc;
    @(posedge clock) disable iff (rst)
    mode_valid && boot_cfg.mode == BMS_DIRECT4_IRC |->
      boot_cfg.direct_exec && boot_cfg.flash_quad &&
      fast_internal_rc_osc_sel && !external_crystal_osc_sel;
  endproperty
  a_direct_irc: assert property (p_direct_irc) // [RULE10]
    else $error("direct fast RC config wrong");

  // A strap level seen before the settle window ends must not be taken.
  property p_strap_wait;
    @(posedge clock) disable iff (rst)
    (!latched && fuse_unprog && settle != 2'h3) |=> !latched;
  endproperty
  a_strap_wait: assert property (p_strap_wait) // [RULE1]
    else $error("strap code taken too early");

  property p_cfg_stays;
    @(posedge clock) disable iff (rst)
    mode_valid |=> mode_valid && $stable(boot_cfg);
  endproperty
  a_cfg_stays: assert property (p_cfg_stays) // [RULE13]
    else $error("boot config changed after valid");

  property p_one_osc;
    @(posedge clock) disable iff (rst)
    !(fast_internal_rc_osc_sel && external_crystal_osc_sel);
  endproperty
  a_one_osc: assert property (p_one_osc) // [RULE9]
    else $error("both oscillators selected");

  c_emmc: cover property (@(posedge clock) disable iff (rst)
    mode_valid && boot_cfg.mode == BMS_EMMC_SRAM);
  c_spi: cover property (@(posedge clock) disable iff (rst)
    mode_valid && third_spi_controller_en);
  c_rom: cover property (@(posedge clock) disable iff (rst)
    mode_valid && boot_cfg.mode == BMS_ROM);
  c_serial: cover property (@(posedge clock) disable iff (rst)
    mode_valid && second_serial_port_en);
  c_external_crystal_osc: cover property (@(posedge clock) disable iff (rst)
    mode_valid && external_crystal_osc_sel);
endmodule
`default_nettype wire

// file: tb/bms_fuse_strap_model.sv
// Model of the fuse array and the boot strap pins facing the selector.
`timescale 1ns/1ps
`default_nettype none
module bms_fuse_strap_model (
  input wire logic [2:0] src,
  input wire logic [2:0] emmc,
  input wire logic [2:0] straps,
  output logic [31:0] fuse_word0,
  output logic [31:0] fuse_word1,
  output logic [2:0] boot_select_pins
);
  // Neighbouring fuse bits are set so that a misplaced field slice shows up.
  assign fuse_word0 = {29'h1555_aaa8, src};
  assign fuse_word1 = {17'h1_5555, emmc, 12'h001};
  // Straps are set while reset is held and stand through its release.
  assign boot_select_pins = straps;
endmodule
`default_nettype wire

// file: tb/tb_boot_mode_selector.sv
// Testbench for the boot mode selector.
`timescale 1ns/1ps
`default_nettype none
module tb_boot_mode_selector;
  import bms_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [2:0] src = 3'h0;
  logic [2:0] emmc = 3'h0;
  logic [2:0] straps = 3'h0;
  wire logic [31:0] fw0;
  wire logic [31:0] fw1;
  wire logic [2:0] pins;
  logic mode_valid;
  bms_cfg_t boot_cfg;
  logic rom_en;
  logic [31:0] rom_base;
  logic ser_en;
  logic spi_en;
  logic pin_en;
  logic irc;
  logic external_crystal_osc;
  int num_errors = 0;
  int cmp_count = 0;

  always #50 clock = ~clock;

  bms_fuse_strap_model u_far (.src(src), .emmc(emmc), .straps(straps),
    .fuse_word0(fw0), .fuse_word1(fw1), .boot_select_pins(pins));

  bms_boot_mode_selector #(.SYNC_STAGES(3)) DUT (.clock(clock), .rst(rst),
    .fuse_word0(fw0), .fuse_word1(fw1), .boot_select_pins(pins),
    .mode_valid(mode_valid), .boot_cfg(boot_cfg), .rom_fetch_en(rom_en),
    .rom_fetch_base(rom_base), .second_serial_port_en(ser_en),
    .third_spi_controller_en(spi_en), .serial_boot_port_pins_en(pin_en),
    .fast_internal_rc_osc_sel(irc), .external_crystal_osc_sel(external_crystal_osc));

  task automatic check(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask

  task automatic end_sim;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Each run is a fresh reset, applied only after the previous run has latched its mode.
  task automatic run(input logic [2:0] s, input logic [2:0] e,
                     input logic [2:0] p, input bms_mode_t m);
    int i;
    @(negedge clock);
    rst = 1'b1;
    src = s;
    emmc = e;
    straps = p;
    repeat (10) @(negedge clock);
    rst = 1'b0;
    #1;
    check(rom_en === 1'b1 && rom_base === ROM_BASE, "rom fetch");
    for (i = 0; i < 12 && mode_valid !== 1'b1; i++) @(negedge clock);
    if (mode_valid !== 1'b1) begin
      check(1'b0, "mode_valid timeout");
      end_sim();
    end
    check(boot_cfg.mode === m, "mode");
    check(ser_en === (m == BMS_UART_SRAM || m == BMS_UART_FLASH) &&
      pin_en === ser_en, "serial enables");
    check(spi_en === (m == BMS_SPI_SRAM), "spi enable");
    if (m != BMS_ROM && m != BMS_UART_SRAM)
      check(external_crystal_osc === (m == BMS_DIRECT4_EXTERNAL_CRYSTAL_OSC) &&
        irc === (m != BMS_DIRECT4_EXTERNAL_CRYSTAL_OSC), "clock");
    if (m inside {BMS_UART_FLASH, BMS_DIRECT1, BMS_DIRECT4_EXTERNAL_CRYSTAL_OSC, BMS_DIRECT4_IRC})
      check(boot_cfg.flash_quad === (m != BMS_DIRECT1) &&
        boot_cfg.direct_exec === m[2], "flash");
    check(boot_cfg.to_sram === (m inside {BMS_UART_SRAM, BMS_SPI_SRAM,
      BMS_EMMC_SRAM}) && boot_cfg.to_flash === (m == BMS_UART_FLASH),
      "target");
    check((boot_cfg.load_if === BMS_IF_EMMC) === (m == BMS_EMMC_SRAM),
      "emmc host");
    if (m == BMS_ROM)
      check(boot_cfg.load_if === BMS_IF_NONE && boot_cfg.direct_exec === 1'b0,
        "rom boot");
    straps = ~p;
    repeat (6) @(negedge clock);
    check(boot_cfg.mode === m && mode_valid === 1'b1, "relatch");
  endtask

  initial begin
    for (int k = 0; k < 7; k++)
      run(3'h0, 3'h0, k[2:0], bms_mode_t'(k[2:0]));
    run(3'h0, EMMC_ENABLE, 3'h3, BMS_EMMC_SRAM);
    run(3'h0, 3'h2, 3'h3, BMS_SPI_SRAM);
    for (int k = 1; k < 7; k++)
      run(k[2:0], 3'h0, ~k[2:0], bms_mode_t'(k[2:0]));
    run(3'h3, EMMC_ENABLE, 3'h0, BMS_EMMC_SRAM);
    run(3'h0, 3'h0, 3'h7, BMS_ROM);
    run(3'h7, 3'h0, 3'h2, BMS_ROM);
    run(3'h0, EMMC_ENABLE, 3'h4, BMS_DIRECT1);
    end_sim();
  end
endmodule
`default_nettype wire
